// *** hw/letc_top.sv ***
// Line exposure timing: external trigger and free-run sequencing,
// low line rate compensation. Registers on a plain strobe port.
// Assumes the trigger pin is asynchronous to REF_CLK.
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// [RL1] Software mode field picks ext edge, level, programmable, or free-run edge, programmable.
// [RL2] Ext programmable exposure length from exposure setting, absolute or raw.
// [RL3] Compensation enable bit under software control, off after reset.
// [RL4] While compensating, sensor is read out repeatedly and data discarded.
// [RL5] Compensation runs in external-trigger modes only, never in free run.
// [RL6] Active compensation stops when line period falls to 256 ms.
// [RL7] Compensation starts once line period reaches 512 ms, giving hysteresis.
// [RL8] Compensation adds 14.2 us before each line on top of start delay.
// [RL9] After stopping, only the first faster line still carries the delay; in level mode that line gets no delay.
// [RL10] With averaging, delay precedes only the first exposure of a series.
// [RL11] Trigger high at least 1.3 us level mode, 100 ns otherwise.
// [RL12] Trigger low at least 2.0 us every period.
// [RL13] Ext edge mode exposure equals trigger period minus 1.8 us.
// [RL14] Too long programmed exposure is kept; triggers during it ignored.
// [RL15] Start delay from rising edge, or falling edge in level mode.
// [RL16] Start delay 1.21 us programmable and level, 2.51 us edge.
// [RL17] Free run makes an internal trigger from period and exposure settings.
// [RL18] Free-run edge exposes full period, readout on each internal rise.
// [RL19] Free-run programmable exposes while internal signal low, readout at rise.
// [RL20] Free-run line period written in microseconds or as raw value.
// [RL21] Software keeps free-run exposure within reported min and max.
// [RL22] Partner must not over-trigger; mode change does not recover.
// [RL23] Ext edge exposes rising edge to rising edge, readout each rise.
// [RL24] Ext level exposes while trigger low, readout on rising edge.
// [RL25] Ext programmable: rising edge starts fixed exposure, readout at end.
// [RL26] Counter measures trigger rising-edge interval against thresholds.
module letc_top #(
   parameter logic [letc_pkg::CW-1:0] COMP_START = letc_pkg::COMP_START_CYC,
   parameter logic [letc_pkg::CW-1:0] COMP_STOP = letc_pkg::COMP_STOP_CYC,
   parameter logic [letc_pkg::CW-1:0] FLUSH_PERIOD = letc_pkg::FLUSH_CYC
) (
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic [letc_pkg::AW-1:0] ADDR,
   input wire logic [letc_pkg::DW-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [letc_pkg::DW-1:0] RDATA,
   input wire logic EXTERNAL_LINE_TRIGGER,
   output letc_pkg::letc_sensor_type SENSOR,
   output logic COMP_ACTIVE
);
   localparam int CW = letc_pkg::CW;

   // Registers
   logic [2:0] mode_reg;
   logic comp_en_reg;
   logic [15:0] exp_abs_reg;
   logic [CW-1:0] exp_cyc_reg;
   logic [15:0] per_abs_reg;
   logic [CW-1:0] per_cyc_reg;
   logic [1:0] avg_reg;
   logic [letc_pkg::DW-1:0] rdata_reg;

   // Trigger synchroniser
   logic trig_meta_reg;
   logic trig_sync_reg;
   logic trig_prev_reg;

   // Sequencer
   logic dly_busy_reg;
   logic [CW-1:0] dly_cnt_reg;
   logic expose_reg;
   logic end_arm_reg;
   logic [CW-1:0] end_cnt_reg;
   logic readout_reg;
   logic flush_reg;
   logic [CW-1:0] flush_cnt_reg;
   logic [1:0] avg_idx_reg;

   // Compensation
   logic [CW-1:0] per_meas_reg;
   logic [CW-1:0] trig_per_reg;
   logic comp_reg;

   // Free run
   typedef enum logic {FR_HIGH, FR_LOW} letc_fr_type;
   letc_fr_type fr_state_reg;
   logic [CW-1:0] fr_cnt_reg;

   // Decode
   wire wr_mode = WR && (ADDR == letc_pkg::OFS_MODE);
   wire wr_comp = WR && (ADDR == letc_pkg::OFS_COMP_EN);
   wire wr_eabs = WR && (ADDR == letc_pkg::OFS_EXP_ABS);
   wire wr_eraw = WR && (ADDR == letc_pkg::OFS_EXP_RAW);
   wire wr_pabs = WR && (ADDR == letc_pkg::OFS_PER_ABS);
   wire wr_praw = WR && (ADDR == letc_pkg::OFS_PER_RAW);
   wire wr_avg = WR && (ADDR == letc_pkg::OFS_AVG);

   // Absolute values are microseconds, raw values are clock cycles
   wire [CW-1:0] eabs_cyc = CW'(WDATA[15:0]) * CW'(letc_pkg::CYC_PER_US); // RL2
   wire [CW-1:0] pabs_cyc = CW'(WDATA[15:0]) * CW'(letc_pkg::CYC_PER_US); // RL20

   // Mode decode
   wire m_edge = (mode_reg == letc_pkg::MODE_EXT_EDGE); // RL1
   wire m_level = (mode_reg == letc_pkg::MODE_EXT_LEVEL); // RL1
   wire m_prog = (mode_reg == letc_pkg::MODE_EXT_PROG); // RL1
   wire m_fr_edge = (mode_reg == letc_pkg::MODE_FR_EDGE); // RL1
   wire m_fr_prog = (mode_reg == letc_pkg::MODE_FR_PROG); // RL1
   wire m_ext = m_edge || m_level || m_prog;
   wire m_fr = m_fr_edge || m_fr_prog;

   // Trigger edges, only from the second stage onward
   wire t_rise = trig_sync_reg && !trig_prev_reg;
   wire t_fall = !trig_sync_reg && trig_prev_reg;

   // Compensation only in external modes
   wire comp_on = comp_en_reg && m_ext; // RL5
   wire per_long = (per_meas_reg >= COMP_START); // RL7
   wire per_short = (per_meas_reg <= COMP_STOP); // RL6
   // Stop line still delayed in edge and programmable modes, where comp_reg is still set at the rise; level mode starts after it clears
   wire comp_line = comp_on && (comp_reg || per_long); // RL9

   // Accepted starts per mode
   wire busy = dly_busy_reg || expose_reg;
   wire st_edge = m_edge && t_rise; // RL23
   wire st_level = m_level && t_fall; // RL15
   // Programmable-mode triggers during an exposure or its delay are dropped
   wire st_prog = m_prog && t_rise && !busy; // RL14
   wire start = st_edge || st_level || st_prog;
   wire [CW-1:0] base_dly = m_edge ? letc_pkg::DLY_EDGE_CYC : letc_pkg::DLY_SHORT_CYC; // RL16
   wire add_comp = comp_line && (avg_idx_reg == 2'h0); // RL10
   wire [CW-1:0] start_dly = base_dly + (add_comp ? letc_pkg::COMP_DLY_CYC : '0); // RL8
   wire [1:0] avg_last = (avg_reg == 2'h2) ? 2'h3 : ((avg_reg == 2'h1) ? 2'h1 : 2'h0);
   wire [1:0] avg_idx_inc = (avg_idx_reg >= avg_last) ? 2'h0 : avg_idx_reg + 2'h1;

   // End of exposure
   wire dly_done = dly_busy_reg && (dly_cnt_reg == 24'h000001);
   wire end_done = end_arm_reg && (end_cnt_reg == 24'h000001);
   wire lvl_end = m_level && t_rise && expose_reg; // RL24
   wire edge_arm = m_edge && t_rise && expose_reg; // RL13
   wire ext_end = end_done || lvl_end;

   // Free-run internal control signal
   wire fr_rise = m_fr && (fr_cnt_reg == 24'h000001);
   wire fr_low = (fr_state_reg == FR_LOW);
   // Low phase begins exposure cycles before the period ends
   wire fr_fall = m_fr_prog && !fr_low && (fr_cnt_reg == exp_cyc_reg + 24'h000001); // RL19
   // Uses the next state so expose falls in the readout cycle
   wire fr_expose = m_fr_edge || (m_fr_prog && (fr_low ? !fr_rise : fr_fall)); // RL18

   // Sensor drive
   wire ext_expose_next = m_ext && (dly_done || (expose_reg && !ext_end));
   // Mode change drops a running exposure, else it could never end
   wire expose_next = !wr_mode && (m_fr ? fr_expose : ext_expose_next);
   wire readout_next = m_fr ? fr_rise : (m_ext && expose_reg && ext_end);
   wire idle_flush = comp_reg && comp_on && !busy; // RL4
   wire flush_next = idle_flush && (flush_cnt_reg == 24'h000001); // RL4

   // Read mux
   wire [letc_pkg::DW-1:0] status = {
      25'h0000000,
      mode_reg,
      1'b0,
      dly_busy_reg,
      expose_reg,
      comp_reg
   };
   logic [letc_pkg::DW-1:0] rd_mux;
   always_comb begin
      case (ADDR)
         letc_pkg::OFS_MODE: rd_mux = {29'h00000000, mode_reg};
         letc_pkg::OFS_COMP_EN: rd_mux = {31'h00000000, comp_en_reg};
         letc_pkg::OFS_EXP_ABS: rd_mux = {16'h0000, exp_abs_reg};
         letc_pkg::OFS_EXP_RAW: rd_mux = {8'h00, exp_cyc_reg};
         letc_pkg::OFS_PER_ABS: rd_mux = {16'h0000, per_abs_reg};
         letc_pkg::OFS_PER_RAW: rd_mux = {8'h00, per_cyc_reg};
         letc_pkg::OFS_EXP_MIN: rd_mux = {8'h00, letc_pkg::EXP_MIN_CYC};
         letc_pkg::OFS_EXP_MAX: rd_mux = {8'h00, letc_pkg::EXP_MAX_CYC};
         letc_pkg::OFS_AVG: rd_mux = {30'h00000000, avg_reg};
         letc_pkg::OFS_STATUS: rd_mux = status;
         letc_pkg::OFS_TRIG_PER: rd_mux = {8'h00, trig_per_reg};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // Software registers
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         mode_reg <= letc_pkg::MODE_RST;
         comp_en_reg <= 1'b0; // RL3
         exp_abs_reg <= letc_pkg::EXP_ABS_RST;
         exp_cyc_reg <= letc_pkg::EXP_RAW_RST;
         per_abs_reg <= letc_pkg::PER_ABS_RST;
         per_cyc_reg <= letc_pkg::PER_RAW_RST;
         avg_reg <= letc_pkg::AVG_RST;
      end else begin
         if (wr_mode) mode_reg <= WDATA[2:0]; // RL1
         if (wr_comp) comp_en_reg <= WDATA[0]; // RL3
         if (wr_eabs) begin
            exp_abs_reg <= WDATA[15:0];
            exp_cyc_reg <= eabs_cyc; // RL2
         end
         if (wr_eraw) exp_cyc_reg <= WDATA[CW-1:0]; // RL2
         if (wr_pabs) begin
            per_abs_reg <= WDATA[15:0];
            per_cyc_reg <= pabs_cyc; // RL20
         end
         if (wr_praw) per_cyc_reg <= WDATA[CW-1:0]; // RL20
         if (wr_avg) avg_reg <= WDATA[1:0];
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) rdata_reg <= 32'h00000000;
      else if (RD) rdata_reg <= rd_mux;
      else rdata_reg <= 32'h00000000;
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         trig_meta_reg <= 1'b0;
         trig_sync_reg <= 1'b0;
         trig_prev_reg <= 1'b0;
      end else begin
         trig_meta_reg <= EXTERNAL_LINE_TRIGGER;
         trig_sync_reg <= trig_meta_reg;
         trig_prev_reg <= trig_sync_reg;
      end
   end

   // Trigger interval measurement, saturating
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         per_meas_reg <= 24'h000000;
         trig_per_reg <= 24'h000000;
      end else if (t_rise) begin
         per_meas_reg <= 24'h000001; // RL26
         trig_per_reg <= per_meas_reg; // RL26
      end else if (per_meas_reg != 24'hFFFFFF) begin
         per_meas_reg <= per_meas_reg + 24'h000001; // RL26
      end
   end

   // Hysteresis: enter at long period, leave at short period
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) comp_reg <= 1'b0;
      else if (!comp_on) comp_reg <= 1'b0; // RL5
      else if (t_rise && comp_reg && per_short) comp_reg <= 1'b0; // RL6
      else if (!comp_reg && per_long) comp_reg <= 1'b1; // RL7
   end

   // Discard readouts while waiting for a slow trigger
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) flush_cnt_reg <= 24'h000000;
      else if (!idle_flush || flush_cnt_reg == 24'h000001) flush_cnt_reg <= FLUSH_PERIOD; // RL4
      else flush_cnt_reg <= flush_cnt_reg - 24'h000001;
   end

   // Averaging series position; a write to the averaging or mode register restarts the series
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) avg_idx_reg <= 2'h0;
      else if (wr_avg || wr_mode) avg_idx_reg <= 2'h0;
      else if (start && m_ext) avg_idx_reg <= avg_idx_inc; // RL10
   end

   // Start delay counter
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         dly_busy_reg <= 1'b0;
         dly_cnt_reg <= 24'h000000;
      end else if (!m_ext) begin
         dly_busy_reg <= 1'b0;
      end else if (start) begin
         dly_busy_reg <= 1'b1; // RL15
         dly_cnt_reg <= start_dly; // RL16
      end else if (dly_done) begin
         dly_busy_reg <= 1'b0;
      end else if (dly_busy_reg) begin
         dly_cnt_reg <= dly_cnt_reg - 24'h000001;
      end
   end

   // Exposure end timer: edge mode offset or programmed length
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         end_arm_reg <= 1'b0;
         end_cnt_reg <= 24'h000000;
      end else if (!m_ext) begin
         end_arm_reg <= 1'b0;
      end else if (edge_arm) begin
         end_arm_reg <= 1'b1;
         end_cnt_reg <= letc_pkg::EDGE_END_CYC; // RL13
      end else if (dly_done && m_prog) begin
         end_arm_reg <= 1'b1;
         // Zero exposure treated as one cycle
         end_cnt_reg <= (exp_cyc_reg == 24'h000000) ? 24'h000001 : exp_cyc_reg; // RL25
      end else if (end_done) begin
         end_arm_reg <= 1'b0;
      end else if (end_arm_reg) begin
         end_cnt_reg <= end_cnt_reg - 24'h000001;
      end
   end

   // Free-run generator; period below two cycles is stretched
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         fr_state_reg <= FR_HIGH;
         fr_cnt_reg <= 24'h000001;
      end else if (!m_fr) begin
         fr_state_reg <= FR_HIGH;
         fr_cnt_reg <= 24'h000001;
      end else begin
         if (fr_rise) fr_cnt_reg <= (per_cyc_reg < 24'h000002) ? 24'h000002 : per_cyc_reg; // RL17
         else fr_cnt_reg <= fr_cnt_reg - 24'h000001;
         case (fr_state_reg)
            FR_HIGH: begin
               if (fr_fall) fr_state_reg <= FR_LOW; // RL19
            end
            FR_LOW: begin
               if (fr_rise) fr_state_reg <= FR_HIGH; // RL19
            end
            default: fr_state_reg <= FR_HIGH;
         endcase
      end
   end

   // Output flops
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         expose_reg <= 1'b0;
         readout_reg <= 1'b0;
         flush_reg <= 1'b0;
      end else begin
         expose_reg <= expose_next; // RL23
         readout_reg <= readout_next; // RL18
         flush_reg <= flush_next; // RL4
      end
   end

   assign RDATA = rdata_reg;
   assign SENSOR = {expose_reg, readout_reg, flush_reg};
   assign COMP_ACTIVE = comp_reg;
endmodule

`default_nettype wire

// *** hw/letc_pkg.sv ***
// Constants and types for line exposure timing control.
// Assumes a single 25 MHz clock; delay, threshold and flush counts derive from CLK_NS.
package letc_pkg;
   localparam int CLK_NS = 40;
   localparam int CW = 24;
   localparam int AW = 8;
   localparam int DW = 32;
   // Register byte offsets
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_COMP_EN = 8'h04;
   localparam logic [7:0] OFS_EXP_ABS = 8'h08;
   localparam logic [7:0] OFS_EXP_RAW = 8'h0C;
   localparam logic [7:0] OFS_PER_ABS = 8'h10;
   localparam logic [7:0] OFS_PER_RAW = 8'h14;
   localparam logic [7:0] OFS_EXP_MIN = 8'h18;
   localparam logic [7:0] OFS_EXP_MAX = 8'h1C;
   localparam logic [7:0] OFS_AVG = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h24;
   localparam logic [7:0] OFS_TRIG_PER = 8'h28;
   // Status field positions
   localparam int ST_COMP_BIT = 0;
   localparam int ST_EXPOSE_BIT = 1;
   localparam int ST_DELAY_BIT = 2;
   localparam int ST_MODE_LSB = 4;
   // Reset values
   localparam logic [2:0] MODE_RST = 3'h0;
   localparam logic [15:0] EXP_ABS_RST = 16'h0064;
   localparam logic [23:0] EXP_RAW_RST = 24'h0009C4;
   localparam logic [15:0] PER_ABS_RST = 16'h03E8;
   localparam logic [23:0] PER_RAW_RST = 24'h0061A8;
   localparam logic [1:0] AVG_RST = 2'h0;
   // Microseconds to cycles
   localparam logic [7:0] CYC_PER_US = 8'(1000 / CLK_NS);
   // Timing, times as printed, counts rounded to nearest cycle
   localparam int DLY_SHORT_NS = 1210;
   localparam int DLY_EDGE_NS = 2510;
   localparam int COMP_DLY_NS = 14200;
   localparam int EDGE_LOSS_NS = 1800;
   localparam int COMP_STOP_MS = 256;
   localparam int COMP_START_MS = 512;
   localparam int FLUSH_US = 1000;
   localparam logic [CW-1:0] DLY_SHORT_CYC = CW'((DLY_SHORT_NS + CLK_NS / 2) / CLK_NS);
   localparam logic [CW-1:0] DLY_EDGE_CYC = CW'((DLY_EDGE_NS + CLK_NS / 2) / CLK_NS);
   localparam logic [CW-1:0] COMP_DLY_CYC = CW'((COMP_DLY_NS + CLK_NS / 2) / CLK_NS);
   localparam logic [CW-1:0] EDGE_LOSS_CYC = CW'((EDGE_LOSS_NS + CLK_NS / 2) / CLK_NS);
   // Edge mode: exposure ends this long after the next rising edge
   localparam logic [CW-1:0] EDGE_END_CYC = DLY_EDGE_CYC - EDGE_LOSS_CYC;
   localparam logic [CW-1:0] COMP_STOP_CYC = CW'(COMP_STOP_MS * 64'd1000000 / CLK_NS);
   localparam logic [CW-1:0] COMP_START_CYC = CW'(COMP_START_MS * 64'd1000000 / CLK_NS);
   localparam logic [CW-1:0] FLUSH_CYC = CW'(FLUSH_US * 1000 / CLK_NS);
   localparam logic [CW-1:0] EXP_MIN_CYC = 24'h000019;
   localparam logic [CW-1:0] EXP_MAX_CYC = 24'hFFFFFF;
   // Mode encoding of the mode register
   typedef enum logic [2:0] {
      MODE_EXT_EDGE = 3'h0,
      MODE_EXT_LEVEL = 3'h1,
      MODE_EXT_PROG = 3'h2,
      MODE_FR_EDGE = 3'h3,
      MODE_FR_PROG = 3'h4
   } letc_mode_type;
   typedef struct packed {
      logic expose;
      logic readout;
      logic flush;
   } letc_sensor_type;
endpackage

// *** testbench/letc_monitor.sv ***
// Port-level checker for letc_top: bus quietness, exposure and compensation relations.
// Assumes it is bound into letc_top and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module letc_monitor #(
   parameter logic [letc_pkg::CW-1:0] COMP_START = letc_pkg::COMP_START_CYC,
   parameter logic [letc_pkg::CW-1:0] COMP_STOP = letc_pkg::COMP_STOP_CYC,
   parameter logic [letc_pkg::CW-1:0] FLUSH_PERIOD = letc_pkg::FLUSH_CYC
) (
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic [letc_pkg::AW-1:0] ADDR,
   input wire logic [letc_pkg::DW-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [letc_pkg::DW-1:0] RDATA,
   input wire logic EXTERNAL_LINE_TRIGGER,
   input wire letc_pkg::letc_sensor_type SENSOR,
   input wire logic COMP_ACTIVE
);
   logic [2:0] mode_reg;
   logic en_reg;
   logic pin_reg;
   logic [letc_pkg::CW-1:0] exp_reg;
   logic [letc_pkg::CW-1:0] len_reg;
   logic [letc_pkg::CW-1:0] gap_reg;
   // Shadow of software settings, rebuilt from the write strobes
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         mode_reg <= letc_pkg::MODE_RST;
         en_reg <= 1'b0;
         exp_reg <= letc_pkg::EXP_RAW_RST;
      end else if (WR) begin
         if (ADDR == letc_pkg::OFS_MODE) mode_reg <= WDATA[2:0];
         if (ADDR == letc_pkg::OFS_COMP_EN) en_reg <= WDATA[0];
         if (ADDR == letc_pkg::OFS_EXP_RAW) exp_reg <= WDATA[23:0];
         if (ADDR == letc_pkg::OFS_EXP_ABS) exp_reg <= 24'(WDATA[15:0]) * 24'(letc_pkg::CYC_PER_US);
      end
   end
   // Raw pin gap runs ahead of the synchronised one, so it undercounts only in the two cycles after a raw rise
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         pin_reg <= 1'b0;
         len_reg <= '0;
         gap_reg <= '0;
      end else begin
         pin_reg <= EXTERNAL_LINE_TRIGGER;
         len_reg <= SENSOR.expose ? len_reg + 1'b1 : '0;
         gap_reg <= (EXTERNAL_LINE_TRIGGER && !pin_reg) ? '0 : gap_reg + {23'h0, !(&gap_reg)};
      end
   end
   rdata_quiet_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      RDATA != '0 |-> $past(RD)) else $error("read data outside read cycle");
   readout_single_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      SENSOR.readout |=> !SENSOR.readout) else $error("readout longer than one cycle");
   readout_fall_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      $fell(SENSOR.expose) && !$past(WR) && !$past(WR, 2) |-> SENSOR.readout)
      else $error("exposure ended without readout");
   comp_mode_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      mode_reg >= 3'h3 && $past(mode_reg) >= 3'h3 |-> !COMP_ACTIVE)
      else $error("compensation active in free run");
   comp_enable_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      !en_reg && !$past(en_reg) |-> !COMP_ACTIVE) else $error("compensation while disabled");
   flush_comp_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      SENSOR.flush |-> COMP_ACTIVE || $past(COMP_ACTIVE)) else $error("flush without compensation");
   flush_gap_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      SENSOR.flush |=> !SENSOR.flush [*8]) else $error("flush pulses too close");
   idle_mode_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      mode_reg > 3'h4 && $past(mode_reg) > 3'h4 && $past(mode_reg, 2) > 3'h4 |-> SENSOR == '0)
      else $error("sensor active in unknown mode");
   prog_length_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      mode_reg == letc_pkg::MODE_EXT_PROG && $fell(SENSOR.expose) && !$past(WR) |->
      len_reg == exp_reg) else $error("programmed exposure length wrong");
   comp_start_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      $rose(COMP_ACTIVE) |-> gap_reg >= COMP_START || gap_reg < 24'h000004)
      else $error("compensation started below threshold");
endmodule
`default_nettype wire

// *** testbench/letc_trig_model.sv ***
// Frame grabber model: drives the line trigger with legal high and low phases.
// Assumes the caller waits for each pulse task to finish before the next.
`timescale 1ns/100ps
`default_nettype none
module letc_trig_model (
   input wire logic clk,
   output logic trig
);
   initial trig = 1'b0;
   // Period is high plus low cycles; phases are never shortened below the minimum
   task automatic pulse(input int high_cyc, input int low_cyc);
      int h;
      int l;
      h = (high_cyc < 33) ? 33 : high_cyc;
      l = (low_cyc < 50) ? 50 : low_cyc;
      @(posedge clk);
      trig <= 1'b1;
      repeat (h) @(posedge clk);
      trig <= 1'b0;
      repeat (l - 1) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// *** testbench/letc_tb_top.sv ***
// Self-checking bench for letc_top: registers, trigger modes, free run, compensation.
// Assumes letc_pkg, letc_top, letc_monitor and letc_trig_model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin mismatches++; \
   $display("BAD t=%0t got %0h exp %0h", $time, (got), (exp)); end end
module letc_tb_top;
   logic REF_CLK = 1'b0;
   logic RST_B = 1'b0;
   logic [7:0] ADDR = 8'h00;
   logic [31:0] WDATA = 32'h0;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic [31:0] RDATA;
   logic EXTERNAL_LINE_TRIGGER;
   letc_pkg::letc_sensor_type SENSOR;
   logic COMP_ACTIVE;
   int mismatches = 0, checked = 0, cyc = 0, t_rise = 0, t_fall = 0, t_exp = 0, len = 0;
   int n_exp = 0, n_rd = 0, t_rd = 0, rd_gap = 0, n_fl = 0;
   logic trig_q = 1'b0, exp_q = 1'b0;
   // Thresholds shortened so compensation is reached in a few thousand cycles
   letc_top #(.COMP_START(24'h0007D0), .COMP_STOP(24'h0003E8), .FLUSH_PERIOD(24'h000032)) uut (
      .REF_CLK(REF_CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .EXTERNAL_LINE_TRIGGER(EXTERNAL_LINE_TRIGGER), .SENSOR(SENSOR),
      .COMP_ACTIVE(COMP_ACTIVE));
   letc_trig_model fg (.clk(REF_CLK), .trig(EXTERNAL_LINE_TRIGGER));
   always #20 REF_CLK = ~REF_CLK;
   always @(posedge REF_CLK) begin
      cyc <= cyc + 1;
      trig_q <= EXTERNAL_LINE_TRIGGER;
      exp_q <= SENSOR.expose;
      if (EXTERNAL_LINE_TRIGGER && !trig_q) t_rise <= cyc;
      if (!EXTERNAL_LINE_TRIGGER && trig_q) t_fall <= cyc;
      if (SENSOR.expose && !exp_q) begin
         t_exp <= cyc;
         n_exp <= n_exp + 1;
      end
      if (!SENSOR.expose && exp_q) len <= cyc - t_exp;
      if (SENSOR.readout) begin
         n_rd <= n_rd + 1;
         rd_gap <= cyc - t_rd;
         t_rd <= cyc;
      end
      if (SENSOR.flush) n_fl <= n_fl + 1;
      if (cyc > 20000) begin
         mismatches++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge REF_CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge REF_CLK);
      WR <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge REF_CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge REF_CLK);
      RD <= 1'b0;
      @(posedge REF_CLK);
      d = RDATA;
   endtask
   // Synchroniser latency is not fixed exactly, so allow a few cycles
   function automatic logic in_rng(input int d, input int base);
      return (d > base) && (d <= base + 4);
   endfunction
   task automatic t_regs();
      logic [7:0] ofs [10];
      logic [31:0] val [10];
      logic [31:0] d;
      ofs = '{letc_pkg::OFS_MODE, letc_pkg::OFS_COMP_EN, letc_pkg::OFS_EXP_ABS,
         letc_pkg::OFS_EXP_RAW, letc_pkg::OFS_PER_ABS, letc_pkg::OFS_PER_RAW,
         letc_pkg::OFS_EXP_MIN, letc_pkg::OFS_EXP_MAX, letc_pkg::OFS_AVG, 8'h30};
      val = '{32'h0, 32'h0, 32'h64, 32'h9C4, 32'h3E8, 32'h61A8, 32'h19, 32'hFFFFFF, 32'h0, 32'h0};
      for (int i = 0; i < 10; i++) begin
         rd(ofs[i], d);
         `CHK(d, val[i])
      end
      wr(letc_pkg::OFS_EXP_MIN, 32'h0);
      wr(8'h30, 32'h5);
      rd(letc_pkg::OFS_EXP_MIN, d);
      `CHK(d, 32'h19)
      wr(letc_pkg::OFS_MODE, 32'h7);
      rd(letc_pkg::OFS_MODE, d);
      `CHK(d, 32'h7)
      `CHK(SENSOR, 3'h0)
      wr(letc_pkg::OFS_COMP_EN, 32'h1);
      rd(letc_pkg::OFS_COMP_EN, d);
      `CHK(d, 32'h1)
      wr(letc_pkg::OFS_COMP_EN, 32'h0);
   endtask
   task automatic t_prog();
      int k;
      wr(letc_pkg::OFS_EXP_RAW, 32'd10);
      wr(letc_pkg::OFS_MODE, 32'(letc_pkg::MODE_EXT_PROG));
      k = n_rd;
      fg.pulse(33, 100);
      `CHK(in_rng(t_exp - t_rise, 30), 1'b1)
      `CHK(len, 10)
      `CHK(n_rd - k, 1)
      wr(letc_pkg::OFS_EXP_ABS, 32'd2);
      fg.pulse(33, 100);
      `CHK(len, 50)
      // Exposure longer than the trigger period: later rises are dropped
      wr(letc_pkg::OFS_EXP_RAW, 32'd200);
      k = n_exp;
      repeat (3) fg.pulse(33, 50);
      repeat (60) @(posedge REF_CLK);
      `CHK(n_exp - k, 1)
      `CHK(len, 200)
   endtask
   task automatic t_edge();
      wr(letc_pkg::OFS_MODE, 32'(letc_pkg::MODE_EXT_EDGE));
      fg.pulse(33, 167);
      `CHK(in_rng(t_exp - t_rise, 63), 1'b1)
      fg.pulse(33, 167);
      `CHK(len, 200 - int'(letc_pkg::DLY_EDGE_CYC - letc_pkg::EDGE_END_CYC))
   endtask
   task automatic t_level();
      wr(letc_pkg::OFS_MODE, 32'(letc_pkg::MODE_EXT_LEVEL));
      fg.pulse(40, 100);
      `CHK(in_rng(t_exp - t_fall, 30), 1'b1)
      fg.pulse(40, 100);
      `CHK(len, 100 - int'(letc_pkg::DLY_SHORT_CYC))
   endtask
   task automatic t_free();
      int k;
      wr(letc_pkg::OFS_PER_ABS, 32'd4);
      wr(letc_pkg::OFS_EXP_ABS, 32'd1);
      wr(letc_pkg::OFS_MODE, 32'(letc_pkg::MODE_FR_PROG));
      repeat (350) @(posedge REF_CLK);
      `CHK(rd_gap, 100)
      `CHK(len, 25)
      wr(letc_pkg::OFS_PER_RAW, 32'd80);
      wr(letc_pkg::OFS_MODE, 32'(letc_pkg::MODE_FR_EDGE));
      wr(letc_pkg::OFS_COMP_EN, 32'h1);
      repeat (200) @(posedge REF_CLK);
      k = n_rd;
      repeat (240) @(posedge REF_CLK);
      `CHK(n_rd - k, 3)
      `CHK(rd_gap, 80)
      `CHK(SENSOR.expose, 1'b1)
      repeat (1700) @(posedge REF_CLK);
      `CHK(COMP_ACTIVE, 1'b0)
   endtask
   task automatic t_comp();
      int k;
      logic [31:0] d;
      wr(letc_pkg::OFS_AVG, 32'h1);
      wr(letc_pkg::OFS_EXP_RAW, 32'd10);
      wr(letc_pkg::OFS_MODE, 32'(letc_pkg::MODE_EXT_PROG));
      repeat (10) @(posedge REF_CLK);
      `CHK(COMP_ACTIVE, 1'b1)
      k = n_fl;
      repeat (200) @(posedge REF_CLK);
      `CHK(n_fl - k, 4)
      fg.pulse(33, 1467);
      `CHK(in_rng(t_exp - t_rise, 385), 1'b1)
      fg.pulse(33, 567);
      `CHK(in_rng(t_exp - t_rise, 30), 1'b1)
      `CHK(COMP_ACTIVE, 1'b1)
      wr(letc_pkg::OFS_AVG, 32'h0);
      fg.pulse(33, 567);
      `CHK(in_rng(t_exp - t_rise, 385), 1'b1)
      `CHK(COMP_ACTIVE, 1'b0)
      fg.pulse(33, 567);
      `CHK(in_rng(t_exp - t_rise, 30), 1'b1)
      rd(letc_pkg::OFS_TRIG_PER, d);
      `CHK(d, 32'h258)
      rd(letc_pkg::OFS_STATUS, d);
      `CHK(d, 32'h20)
   endtask
   initial begin
      repeat (16) @(posedge REF_CLK);
      RST_B <= 1'b1;
      t_regs();
      t_prog();
      t_edge();
      t_level();
      t_free();
      t_comp();
      stop_test();
   end
endmodule
bind letc_top letc_monitor #(.COMP_START(COMP_START), .COMP_STOP(COMP_STOP),
   .FLUSH_PERIOD(FLUSH_PERIOD)) mon (.REF_CLK(REF_CLK), .RST_B(RST_B), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
   .EXTERNAL_LINE_TRIGGER(EXTERNAL_LINE_TRIGGER), .SENSOR(SENSOR), .COMP_ACTIVE(COMP_ACTIVE));
`default_nettype wire
